// ### core/ioxp_regs.svh
`ifndef IOXP_REGS_SVH
`define IOXP_REGS_SVH

// Fixed upper four bits of the seven-bit slave address
`define IOXP_ADDR_FIXED 4'h4
// Register group codes, taken from pointer bits 2:1
`define IOXP_GRP_IN 2'h0
`define IOXP_GRP_OUT 2'h1
`define IOXP_GRP_POL 2'h2
`define IOXP_GRP_DIR 2'h3
// Reset values, port 1 in the upper byte
`define IOXP_OUT_RST 16'hFFFF
`define IOXP_POL_RST 16'h0000
`define IOXP_DIR_RST 16'hFFFF
// Command pointer reset value
`define IOXP_CMD_RST 3'h0
// Bit counts of one byte on the bus
`define IOXP_BYTE_BITS 4'h8
`define IOXP_LAST_TX 4'h7
// System cycles until the pin synchronisers hold valid data
`define IOXP_SETTLE 2'h3

`endif

// ### core/ioxp_pkg.sv
package ioxp_pkg;

	// Transaction engine states, one-hot
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_AACK = 9'h004,
		ST_CMD = 9'h008,
		ST_CACK = 9'h010,
		ST_WR = 9'h020,
		ST_WACK = 9'h040,
		ST_RD = 9'h080,
		ST_RACK = 9'h100
	} ioxp_state_t;

	// Bus levels and the bit sampled on the link clock, crossed together
	typedef struct packed {
		logic scl;
		logic sda;
		logic tog;
		logic dat;
	} ioxp_link_t;

endpackage

// ### core/ioxp_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-stage level synchroniser; only the second stage is visible outside
module ioxp_sync #(
	parameter int W = 1
) (
	input wire logic clock, // System clock
	input wire logic rst_n, // Synchronous reset, active low
	input wire logic [W-1:0] d, // Asynchronous levels
	output logic [W-1:0] q // Synchronised levels
);

	logic [W-1:0] meta_ff; // First stage, read by q only

	// Refuse a zero-width instance
	if (W < 1) begin : g_chk
		$error("ioxp_sync: W must be at least 1");
	end

	// Both stages clear on reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			meta_ff <= '0;
			q <= '0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end

endmodule

`default_nettype wire

// ### core/ioxp_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ioxp_regs.svh"

module ioxp_top #(
	parameter int PORT_W = 8
) (
	input wire logic clock, // System clock, 100 MHz
	input wire logic rst_n, // Reset, active low; synchronous except in the link domain, where it acts without the bus clock
	input wire logic scl, // Bus clock, second domain
	input wire logic sda_i, // Bus data level
	output logic sda_o, // Bus data drive value, always low
	output logic sda_oe_n, // Bus data enable, low pulls low
	input wire logic addr_select_bit0, // Address select input 0
	input wire logic addr_select_bit1, // Address select input 1
	input wire logic addr_select_bit2, // Address select input 2
	input wire logic [15:0] port_i, // Pin levels, port 1 high byte
	output logic [15:0] port_o, // Pin drive values
	output logic [15:0] port_oe_n, // Pin enables, low drives
	output logic int_n_o, // Interrupt drive value, always low
	output logic int_n_oe_n // Interrupt enable, low asserts
);

	// Only byte-wide ports are served by the pair logic
	if (PORT_W != 8) begin : g_chk
		$error("ioxp_top: PORT_W must be 8");
	end

	// Link domain: sample data on every rising bus clock edge.
	// The bus clock stands still during reset, so the reset acts without
	// it; an unknown toggle would otherwise hide every later bit.
	logic link_dat_ff; // Bit seen at the last rising edge
	logic link_tog_ff; // Flips once per rising edge

	always_ff @(posedge scl or negedge rst_n) begin
		if (!rst_n) begin
			link_dat_ff <= 1'b0;
			link_tog_ff <= 1'b0;
		end else begin
			link_dat_ff <= sda_i;
			link_tog_ff <= ~link_tog_ff;
		end
	end

	// Crossing of bus levels and the sampled bit
	ioxp_pkg::ioxp_link_t link_raw; // Raw link signals
	ioxp_pkg::ioxp_link_t link_s; // Synchronised link signals
	logic [18:0] pins_s; // Synchronised ports and selects
	logic [15:0] pin_s; // Synchronised port levels
	logic [2:0] asel_s; // Synchronised select levels

	assign link_raw = '{scl: scl, sda: sda_i, tog: link_tog_ff, dat: link_dat_ff};

	ioxp_sync #(.W($bits(ioxp_pkg::ioxp_link_t))) u_link_sync (
		.clock(clock),
		.rst_n(rst_n),
		.d(link_raw),
		.q(link_s)
	);

	ioxp_sync #(.W(19)) u_pin_sync (
		.clock(clock),
		.rst_n(rst_n),
		.d({addr_select_bit2, addr_select_bit1, addr_select_bit0, port_i}),
		.q(pins_s)
	);

	assign pin_s = pins_s[15:0];
	assign asel_s = pins_s[18:16];

	// Previous synchronised values for edge detection
	ioxp_pkg::ioxp_link_t prev_ff; // Link signals one cycle back

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			prev_ff <= '0;
		end else begin
			prev_ff <= link_s;
		end
	end

	// Bus events; the toggle arrives long before the next falling edge
	logic start_evt; // Data falls while clock high
	logic stop_evt; // Data rises while clock high
	logic bit_evt; // A rising edge was sampled
	logic fall_evt; // Bus clock fell

	assign start_evt = link_s.scl & prev_ff.scl & prev_ff.sda & ~link_s.sda;
	assign stop_evt = link_s.scl & prev_ff.scl & ~prev_ff.sda & link_s.sda;
	assign bit_evt = link_s.tog ^ prev_ff.tog;
	assign fall_evt = prev_ff.scl & ~link_s.scl;

	// Engine state and its next values
	ioxp_pkg::ioxp_state_t st_ff, nxt_st; // Transaction state
	logic [3:0] cnt_ff, nxt_cnt; // Bits taken or sent
	logic [7:0] sh_ff, nxt_sh; // Receive shifter
	logic [7:0] tx_ff, nxt_tx; // Transmit shifter
	logic [2:0] cur_ff, nxt_cur; // Register being accessed
	logic [2:0] cmd_ff, nxt_cmd; // Stored command pointer
	logic rw_ff, nxt_rw; // Read direction of this transfer
	logic sel_ff, nxt_sel; // This device addressed since start
	logic nack_ff, nxt_nack; // Master acknowledge level
	logic sda_oe_n_ff, nxt_sda_oe_n; // Registered data enable
	logic wr_en; // Store received byte
	logic cap_in; // Capture input register
	logic stop_clr; // Stop clears both ports
	logic [1:0] rd_clr; // Port read clears its flag

	// Configuration and output registers, port 1 in the upper byte
	logic [15:0] out_ff; // Output values
	logic [15:0] pol_ff; // Inversion bits
	logic [15:0] dir_ff; // Direction bits, one is input
	logic [15:0] in_ff; // Captured input register
	logic [15:0] ref_ff; // Levels at last clear, per pin
	logic [1:0] pend; // Pending change per port
	logic [1:0] init_ff; // Settle counter after reset
	logic init_done; // Synchronisers hold valid data
	logic int_oe_n_ff; // Registered interrupt enable

	assign init_done = (init_ff == `IOXP_SETTLE);

	// Address match on the fixed part and the select levels
	logic addr_hit; // Received address is ours
	assign addr_hit = (sh_ff[7:1] == {`IOXP_ADDR_FIXED, asel_s});

	// Read selection; in the read acknowledge the partner register
	// is the one about to be sent
	logic rd_lsb; // Byte select for the read mux
	logic [15:0] rd_word; // Selected register pair
	logic [7:0] rd_byte; // Byte to send next

	assign rd_lsb = (st_ff == ioxp_pkg::ST_RACK) ? ~cur_ff[0] : cur_ff[0];
	assign rd_word = (cur_ff[2:1] == `IOXP_GRP_IN) ? in_ff :
		(cur_ff[2:1] == `IOXP_GRP_OUT) ? out_ff :
		(cur_ff[2:1] == `IOXP_GRP_POL) ? pol_ff : dir_ff;
	assign rd_byte = rd_lsb ? rd_word[15:8] : rd_word[7:0];

	// Write merge of the received byte into the addressed pair
	logic [15:0] wr_mask; // Bits of the addressed byte
	logic [15:0] wr_word; // Received byte in both lanes
	logic wr_out, wr_pol, wr_dir; // Group write strobes

	assign wr_mask = cur_ff[0] ? 16'hFF00 : 16'h00FF;
	assign wr_word = {sh_ff, sh_ff};
	assign wr_out = wr_en & (cur_ff[2:1] == `IOXP_GRP_OUT);
	assign wr_pol = wr_en & (cur_ff[2:1] == `IOXP_GRP_POL);
	assign wr_dir = wr_en & (cur_ff[2:1] == `IOXP_GRP_DIR);

	// Next-state logic. Start and stop win over bit events, since a
	// start or stop can only occur while the bus clock is high.
	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_sh = sh_ff;
		nxt_tx = tx_ff;
		nxt_cur = cur_ff;
		nxt_cmd = cmd_ff;
		nxt_rw = rw_ff;
		nxt_sel = sel_ff;
		nxt_nack = nack_ff;
		wr_en = 1'b0;
		cap_in = 1'b0;
		stop_clr = 1'b0;
		rd_clr = 2'b00;
		if (stop_evt) begin
			// Only a stop of our own transfer clears the interrupt
			nxt_st = ioxp_pkg::ST_IDLE;
			nxt_sel = 1'b0;
			nxt_cur = cmd_ff;
			stop_clr = sel_ff;
		end else if (start_evt) begin
			nxt_st = ioxp_pkg::ST_ADDR;
			nxt_cnt = 4'h0;
			if (sel_ff) begin
				nxt_cmd = cur_ff;
			end else begin
				nxt_cur = cmd_ff;
			end
		end else if (bit_evt) begin
			case (st_ff)
				ioxp_pkg::ST_ADDR, ioxp_pkg::ST_CMD, ioxp_pkg::ST_WR: begin
					if (cnt_ff != `IOXP_BYTE_BITS) begin
						nxt_sh = {sh_ff[6:0], link_s.dat};
						nxt_cnt = cnt_ff + 4'h1;
					end
				end
				ioxp_pkg::ST_AACK: begin
					cap_in = rw_ff;
				end
				ioxp_pkg::ST_RACK: begin
					cap_in = 1'b1;
					nxt_nack = link_s.dat;
				end
				default: begin
				end
			endcase
		end else if (fall_evt) begin
			case (st_ff)
				ioxp_pkg::ST_ADDR: begin
					if (cnt_ff == `IOXP_BYTE_BITS) begin
						if (addr_hit) begin
							nxt_st = ioxp_pkg::ST_AACK;
							nxt_sel = 1'b1;
							nxt_rw = sh_ff[0];
						end else begin
							nxt_st = ioxp_pkg::ST_IDLE;
						end
					end
				end
				ioxp_pkg::ST_AACK: begin
					nxt_cnt = 4'h0;
					if (rw_ff) begin
						nxt_st = ioxp_pkg::ST_RD;
						nxt_tx = rd_byte;
					end else begin
						nxt_st = ioxp_pkg::ST_CMD;
					end
				end
				ioxp_pkg::ST_CMD: begin
					if (cnt_ff == `IOXP_BYTE_BITS) begin
						nxt_cmd = sh_ff[2:0];
						nxt_cur = sh_ff[2:0];
						nxt_st = ioxp_pkg::ST_CACK;
					end
				end
				ioxp_pkg::ST_CACK, ioxp_pkg::ST_WACK: begin
					nxt_st = ioxp_pkg::ST_WR;
					nxt_cnt = 4'h0;
				end
				ioxp_pkg::ST_WR: begin
					if (cnt_ff == `IOXP_BYTE_BITS) begin
						wr_en = 1'b1;
						nxt_cur = {cur_ff[2:1], ~cur_ff[0]};
						nxt_st = ioxp_pkg::ST_WACK;
					end
				end
				ioxp_pkg::ST_RD: begin
					if (cnt_ff == `IOXP_LAST_TX) begin
						// Acknowledge bit begins: a read port clears here
						nxt_st = ioxp_pkg::ST_RACK;
						if (cur_ff[2:1] == `IOXP_GRP_IN) begin
							rd_clr[cur_ff[0]] = 1'b1;
						end
					end else begin
						nxt_tx = {tx_ff[6:0], 1'b1};
						nxt_cnt = cnt_ff + 4'h1;
					end
				end
				ioxp_pkg::ST_RACK: begin
					if (nack_ff) begin
						nxt_st = ioxp_pkg::ST_IDLE;
					end else begin
						nxt_cur = {cur_ff[2:1], ~cur_ff[0]};
						nxt_tx = rd_byte;
						nxt_st = ioxp_pkg::ST_RD;
						nxt_cnt = 4'h0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Data line pulls low in the address, command and write acknowledges and for zero read bits
	assign nxt_sda_oe_n = ~((nxt_st == ioxp_pkg::ST_AACK) |
		(nxt_st == ioxp_pkg::ST_CACK) | (nxt_st == ioxp_pkg::ST_WACK) |
		((nxt_st == ioxp_pkg::ST_RD) & ~nxt_tx[7]));

	// Engine registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_ff <= ioxp_pkg::ST_IDLE;
			cnt_ff <= 4'h0;
			sh_ff <= 8'h00;
			tx_ff <= 8'hFF;
			cur_ff <= `IOXP_CMD_RST;
			cmd_ff <= `IOXP_CMD_RST;
			rw_ff <= 1'b0;
			sel_ff <= 1'b0;
			nack_ff <= 1'b0;
			sda_oe_n_ff <= 1'b1;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			tx_ff <= nxt_tx;
			cur_ff <= nxt_cur;
			cmd_ff <= nxt_cmd;
			rw_ff <= nxt_rw;
			sel_ff <= nxt_sel;
			nack_ff <= nxt_nack;
			sda_oe_n_ff <= nxt_sda_oe_n;
		end
	end

	// Register file; outputs hold across any stop
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			out_ff <= `IOXP_OUT_RST;
			pol_ff <= `IOXP_POL_RST;
			dir_ff <= `IOXP_DIR_RST;
		end else begin
			out_ff <= wr_out ? ((out_ff & ~wr_mask) | (wr_word & wr_mask)) : out_ff;
			pol_ff <= wr_pol ? ((pol_ff & ~wr_mask) | (wr_word & wr_mask)) : pol_ff;
			dir_ff <= wr_dir ? ((dir_ff & ~wr_mask) | (wr_word & wr_mask)) : dir_ff;
		end
	end

	// Input register: pins with inversion applied, loaded while settling
	// and at each acknowledge rising edge of a read
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			in_ff <= 16'h0000;
		end else if (!init_done || cap_in) begin
			in_ff <= pin_s ^ pol_ff;
		end
	end

	// Settle counter keeps the interrupt quiet until pins are valid
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			init_ff <= 2'h0;
		end else if (!init_done) begin
			init_ff <= init_ff + 2'h1;
		end
	end

	// Per-port change detection. A flag is a level compare against the
	// reference, so a return to the old level clears it and any later
	// change of an input-mode pin sets it again; a change landing exactly on the clear cycle
	// is absorbed into the new reference, which is the known loss.
	for (genvar g = 0; g < 2; g++) begin : g_port
		logic [7:0] diff; // Input pins away from the reference
		assign diff = (pin_s[g*8 +: 8] ^ ref_ff[g*8 +: 8]) & dir_ff[g*8 +: 8];
		assign pend[g] = init_done & (|diff);

		always_ff @(posedge clock) begin
			if (!rst_n) begin
				ref_ff[g*8 +: 8] <= 8'h00;
			end else if (!init_done || rd_clr[g] || stop_clr) begin
				ref_ff[g*8 +: 8] <= pin_s[g*8 +: 8];
			end
		end
	end

	// Interrupt enable registered to keep glitches off the pin
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			int_oe_n_ff <= 1'b1;
		end else begin
			int_oe_n_ff <= ~(|pend);
		end
	end

	// Pin drive; open-drain lines only ever pull low
	assign sda_o = 1'b0;
	assign sda_oe_n = sda_oe_n_ff;
	assign int_n_o = 1'b0;
	assign int_n_oe_n = int_oe_n_ff;
	assign port_o = out_ff;
	assign port_oe_n = dir_ff;

	// Checks on the system clock
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	a_int_follows_flags: assert property (
		(|pend) |=> !int_n_oe_n) else $error("interrupt not asserted");
	a_int_release: assert property (
		(pend == 2'b00) |=> int_n_oe_n) else $error("interrupt not released");
	a_output_no_int: assert property (
		(dir_ff[7:0] == 8'h00) |-> !pend[0]) else $error("output pin set flag");
	a_input_edge_flags: assert property (
		(init_done && ((pin_s[15:8] ^ ref_ff[15:8]) & dir_ff[15:8]) != 8'h00)
		|-> pend[1]) else $error("input change not flagged");
	a_ack_drives_low: assert property (
		(st_ff == ioxp_pkg::ST_AACK) |-> !sda_oe_n) else $error("address not acked");
	a_pair_alternates: assert property (
		wr_en |=> (cur_ff[0] != $past(cur_ff[0])) && (cur_ff[2:1] == $past(cur_ff[2:1])))
		else $error("pointer did not alternate");
	a_write_lands: assert property (
		(wr_en && cur_ff == 3'h2) |=> port_o[7:0] == $past(sh_ff))
		else $error("write lost");
	a_restart_pointer: assert property (
		(start_evt && !stop_evt && sel_ff) |=> cmd_ff == $past(cur_ff))
		else $error("pointer not refreshed");
	a_read_clear_port: assert property (
		(rd_clr == 2'b01) |=> (ref_ff[7:0] == $past(pin_s[7:0])) &&
		(ref_ff[15:8] == $past(ref_ff[15:8])) || $past(stop_clr))
		else $error("read cleared wrong port");
	a_master_ack_free: assert property (
		(st_ff == ioxp_pkg::ST_RACK) |-> sda_oe_n) else $error("data held in ack");

	c_write_pair: cover property (wr_en ##[1:1000] wr_en);
	c_read_burst: cover property ((st_ff == ioxp_pkg::ST_RACK) && !nack_ff && fall_evt);
	c_restart: cover property (start_evt && sel_ff);
	c_interrupt: cover property ($fell(int_n_oe_n));

endmodule

`default_nettype wire

// ### dv/ioxp_master.sv
`timescale 1ns/10ps
`default_nettype none

// Bus master model; the clock stands high between frames and the data line is open drain
module ioxp_master (
	input wire logic lclk, // Bit timing tick, 32 ns period
	input wire logic sda_line, // Resolved data wire
	output logic scl, // Bus clock, idles high
	output logic sda_rel // One releases data, zero pulls low
);
	localparam int PH = 4; // Ticks per clock phase, long enough for the synchronisers

	// Idle bus: both lines released
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end

	// Wait a number of ticks
	task automatic wt(input int n);
		repeat (n) @(posedge lclk);
	endtask

	// Start or repeated start: data falls while the clock is high
	task automatic start();
		wt(1);
		sda_rel = 1'b1;
		wt(PH);
		scl = 1'b1;
		wt(PH);
		sda_rel = 1'b0;
		wt(PH);
		scl = 1'b0;
	endtask

	// Stop: data rises while the clock is high
	task automatic stop();
		wt(1);
		sda_rel = 1'b0;
		wt(PH);
		scl = 1'b1;
		wt(PH);
		sda_rel = 1'b1;
		wt(PH);
	endtask

	// One bit; data changes only while the clock is low, sampled at the end of high
	task automatic bit_x(input logic b, output logic r);
		wt(1);
		sda_rel = b;
		wt(PH);
		scl = 1'b1;
		wt(PH);
		r = sda_line;
		scl = 1'b0;
	endtask

	// Byte out, MSB first, then the slave's acknowledge (zero means acknowledged)
	task automatic byte_w(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, ack);
	endtask

	// Byte in; nack set on the final byte of a read
	task automatic byte_r(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(nack, r);
	endtask
endmodule

`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ioxp_regs.svh"

module tb;
	localparam int LIMIT = 60000; // Cycle ceiling, about three times the expected run
	logic clock, rst_n, lclk, scl, sda_rel, sda_oe_n, int_n_oe_n;
	logic [2:0] asel; // Address select levels
	logic [15:0] ext, port_o, port_oe_n; // Pin levels and drives
	wire logic sda_line; // Open-drain data wire with pull-up
	int n_fail, check_count, cyc;
	int regs [8]; // Model of the writable registers
	int cmd_m, cur; // Model of stored command and current register
	logic [15:0] ref_m; // Model of the interrupt reference levels

	assign sda_line = sda_rel & sda_oe_n;

	// System clock, 10 ns
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Link tick, 32 ns, offset so it never lines up with the system clock
	initial begin
		lclk = 1'b0;
		#7.3;
		forever #16 lclk = ~lclk;
	end

	ioxp_top i_ioxp_top (.clock(clock), .rst_n(rst_n), .scl(scl), .sda_i(sda_line),
		.sda_o(), .sda_oe_n(sda_oe_n), .addr_select_bit0(asel[0]),
		.addr_select_bit1(asel[1]), .addr_select_bit2(asel[2]), .port_i(ext),
		.port_o(port_o), .port_oe_n(port_oe_n), .int_n_o(), .int_n_oe_n(int_n_oe_n));

	ioxp_master i_ioxp_master (.lclk(lclk), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));

	// Compare and count
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic conclude();
		if (n_fail == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Register pair as a 16-bit word, port 1 high
	function automatic logic [15:0] w16(input int lo);
		return {regs[lo+1][7:0], regs[lo][7:0]};
	endfunction

	// Expected read value; input registers show the pins through the inversion bits
	function automatic int rv(input int p);
		if (p < 2) return ((ext >> 8 * p) & 16'h00FF) ^ regs[4+p];
		return regs[p];
	endfunction

	// Expected interrupt enable: low while an input-mode pin differs from its reference
	function automatic logic xn();
		return ~|((ext ^ ref_m) & w16(6));
	endfunction

	// Address byte with the direction bit last
	function automatic logic [7:0] adr(input logic rw);
		return {`IOXP_ADDR_FIXED, asel, rw};
	endfunction

	// Write transfer; bad flips an address select bit so nobody answers
	task automatic wr(input int cmd, input int n, input bit bad);
		logic a;
		logic [7:0] d;
		i_ioxp_master.start();
		i_ioxp_master.byte_w(adr(1'b0) ^ {6'h00, bad, 1'b0}, a);
		chk("addr_ack", 16'(a), 16'(bad));
		if (!bad) begin
			i_ioxp_master.byte_w(8'(cmd), a);
			cmd_m = cmd;
			cur = cmd;
			for (int i = 0; i < n; i++) begin
				d = 8'($urandom);
				i_ioxp_master.byte_w(d, a);
				chk("wr_ack", 16'(a), 16'h0000);
				if (cur > 1) regs[cur] = d;
				cur = cur ^ 1;
			end
		end
		i_ioxp_master.stop();
		if (!bad) ref_m = ext;
		repeat (6) @(posedge clock);
		chk("port_o", port_o, w16(2));
		chk("port_oe_n", port_oe_n, w16(6));
		chk("int_wr", 16'(int_n_oe_n), 16'(xn()));
	endtask

	// Read transfer; a negative cmd skips the command phase, rs inserts a restart
	task automatic rd(input int cmd, input int n, input int rs);
		logic a;
		logic [7:0] d;
		cur = cmd_m;
		i_ioxp_master.start();
		if (cmd >= 0) begin
			i_ioxp_master.byte_w(adr(1'b0), a);
			i_ioxp_master.byte_w(8'(cmd), a);
			cur = cmd;
			i_ioxp_master.start();
		end
		cmd_m = cur;
		i_ioxp_master.byte_w(adr(1'b1), a);
		chk("rd_ack", 16'(a), 16'h0000);
		for (int i = 0; i < n; i++) begin
			if (i == rs) begin
				i_ioxp_master.start();
				cmd_m = cur;
				i_ioxp_master.byte_w(adr(1'b1), a);
			end
			// A restart needs a released data line, so the byte before it is refused
			i_ioxp_master.byte_r(i == n - 1 || i + 1 == rs, d);
			chk("rd_data", 16'(d), 16'(rv(cur)));
			if (cur < 2) ref_m[8*cur+:8] = ext[8*cur+:8];
			chk("int_rd", 16'(int_n_oe_n), 16'(xn()));
			if (i < n - 1 && i + 1 != rs) cur = cur ^ 1;
		end
		i_ioxp_master.stop();
		ref_m = ext;
	endtask

	// Change the pins, let the synchronisers settle, check the interrupt
	task automatic pins(input logic [15:0] v);
		@(posedge clock);
		ext <= v;
		repeat (6) @(posedge clock);
		chk("int_pin", 16'(int_n_oe_n), 16'(xn()));
	endtask

	// Hang guard
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_fail++;
			conclude();
		end
	end

	// Main sequence
	initial begin
		rst_n = 1'b0;
		ext = 16'h0000;
		asel = 3'h0;
		n_fail = 0;
		check_count = 0;
		void'($urandom(32'h4FBC6EFB));
		for (int p = 0; p < 2; p++) begin
			regs[2+p] = (`IOXP_OUT_RST >> 8 * p) & 255;
			regs[4+p] = (`IOXP_POL_RST >> 8 * p) & 255;
			regs[6+p] = (`IOXP_DIR_RST >> 8 * p) & 255;
		end
		cmd_m = `IOXP_CMD_RST;
		@(posedge clock);
		asel <= 3'($urandom);
		ext <= 16'($urandom);
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		repeat (10) @(posedge clock);
		ref_m = ext;
		chk("rst_port_o", port_o, w16(2));
		chk("rst_oe_n", port_oe_n, w16(6));
		chk("rst_int", 16'(int_n_oe_n), 16'h0001);
		wr(3, 3, 0);
		wr(7, 2, 0);
		wr(4, 2, 0);
		wr(0, 2, 0);
		rd(0, 3, -1);
		for (int c = 2; c < 8; c++) rd(c, 2, -1);
		rd(1, 3, 2);
		rd(-1, 1, -1);
		pins(~ext);
		pins(~ext);
		pins(~ext);
		rd(1, 2, -1);
		pins(ext ^ ~w16(6));
		pins(~ext);
		wr(2, 1, 1);
		wr(2, 1, 0);
		conclude();
	end
endmodule

`default_nettype wire
